/* logic/meim_event_irq_mask_low.v */
// low event interrupt mask with status, clear and mode registers
// assumes event inputs are single-cycle pulses or levels in the ref_clk domain,
// pulse pins asynchronous; Wishbone classic slave on the same clock
// Function
// - bit 0 enables total active half-full
// - bit 1 enables fundamental active half-full
// - bit 2 enables total reactive half-full
// - bit 3 enables fundamental reactive half-full
// - bit 4 enables apparent energy half-full
// - bit 5 enables line-cycle accumulation done
// - bits 6-8 phase active sign, mode-selected
// - bits 10-12 phase reactive sign, mode-selected
// - bit 9 first pulse sum sign
// - bit 13 second pulse sum sign
// - bit 18 third pulse sum sign
// - bit 14 first pulse falling edge, even disabled
// - bit 15 second pulse falling edge, even disabled
// - bit 16 third pulse falling edge, even disabled
// - pulse power selects at mode bits 2:0/5:3/8:6
// - bit 17 enables dsp cycle done
// - bits 31:19 reserved, zero, no effect
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "meim_regs.vh"

module meim_event_irq_mask_low (
   // clock and reset
   input wire ref_clk,
   input wire rst,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [`MEIM_ADDR_W-1:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg wb_err_o,
   // accumulator bit 30 of each phase, per energy kind
   input wire [2:0] totActBit30,
   input wire [2:0] fundActBit30,
   input wire [2:0] totReactBit30,
   input wire [2:0] fundReactBit30,
   input wire [2:0] apparentBit30,
   // line-cycle accumulation done pulse
   input wire lineCycDone,
   // power signs per phase, 1 = negative
   input wire [2:0] totActSign,
   input wire [2:0] fundActSign,
   input wire [2:0] totReactSign,
   input wire [2:0] fundReactSign,
   // sign of summed power per pulse datapath, 1 = negative
   input wire [2:0] pulseSumSign,
   // internal active-low pulse outputs, before pin disable
   input wire energyPulse1N,
   input wire energyPulse2N,
   input wire energyPulse3N,
   // dsp cycle done pulse
   input wire dspCycleDone,
   // mode outputs to the datapaths
   output wire [2:0] pulseOut1PowerSel,
   output wire [2:0] pulseOut2PowerSel,
   output wire [2:0] pulseOut3PowerSel,
   output wire pulseOut1Disable,
   output wire pulseOut2Disable,
   output wire pulseOut3Disable,
   output wire activeSignSourceSel,
   output wire reactiveSignSourceSel,
   // interrupt request, active high level
   output wire irq
);

   reg [`MEIM_EV_W-1:0] maskFf;
   reg [`MEIM_EV_W-1:0] statusFf;
   reg [`MEIM_MM_W-1:0] mmodeFf;
   reg [`MEIM_CF_W-1:0] cfmodeFf;
   reg [14:0] bit30PrevFf;
   reg [2:0] actSgnPrevFf;
   reg [2:0] reactSgnPrevFf;
   reg [2:0] sumSgnPrevFf;
   reg [2:0] pulseS1Ff;
   reg [2:0] pulseS2Ff;
   reg [2:0] pulseS3Ff;
   reg [2:0] pulseStableFf;
   reg [`MEIM_EV_W-1:0] nxt_statusFf;
   reg [`MEIM_EV_W-1:0] events;
   wire [14:0] bit30Now;
   wire [2:0] actSgnNow;
   wire [2:0] reactSgnNow;
   wire [2:0] pulseFall;
   wire [2:0] pulseAgree;
   wire [2:0] pulseNxt;
   wire [`MEIM_ADDR_W-3:0] wordIdx;
   wire access;
   wire wrStrobe;
   wire hitMask;
   wire hitStatus;
   wire hitClear;
   wire hitMm;
   wire hitCf;
   wire mapped;

   // the byte address carries the printed index in its upper bits
   assign wordIdx = wb_adr_i[`MEIM_ADDR_W-1:2];
   assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign hitMask = (wordIdx == `MEIM_IDX_ENABLE_LOW);
   assign hitStatus = (wordIdx == `MEIM_IDX_STATUS);
   assign hitClear = (wordIdx == `MEIM_IDX_CLEAR);
   assign hitMm = (wordIdx == `MEIM_IDX_MEASUREMENT_MODE_REG);
   assign hitCf = (wordIdx == `MEIM_IDX_PULSE_OUTPUT_MODE_REG);
   assign mapped = hitMask | hitStatus | hitClear | hitMm | hitCf;
   assign wrStrobe = access & wb_we_i & mapped;

   // mode fields feed the pulse and sign datapaths
   assign pulseOut1PowerSel = cfmodeFf[`MEIM_CF_SEL1_LO+2:`MEIM_CF_SEL1_LO];
   assign pulseOut2PowerSel = cfmodeFf[`MEIM_CF_SEL2_LO+2:`MEIM_CF_SEL2_LO];
   assign pulseOut3PowerSel = cfmodeFf[`MEIM_CF_SEL3_LO+2:`MEIM_CF_SEL3_LO];
   assign pulseOut1Disable = cfmodeFf[`MEIM_CF_DIS1];
   assign pulseOut2Disable = cfmodeFf[`MEIM_CF_DIS2];
   assign pulseOut3Disable = cfmodeFf[`MEIM_CF_DIS3];
   assign activeSignSourceSel = mmodeFf[`MEIM_MM_ACTSEL];
   assign reactiveSignSourceSel = mmodeFf[`MEIM_MM_REACTSEL];

   // sign sources picked by the measurement mode bits
   assign actSgnNow = mmodeFf[`MEIM_MM_ACTSEL] ? fundActSign : totActSign;
   assign reactSgnNow = mmodeFf[`MEIM_MM_REACTSEL] ? fundReactSign : totReactSign;
   assign bit30Now = {apparentBit30, fundReactBit30, totReactBit30, fundActBit30, totActBit30};

   // pulse pins: three stages, change counts when stages two and three agree
   assign pulseNxt = {energyPulse3N, energyPulse2N, energyPulse1N};
   assign pulseAgree = ~(pulseS2Ff ^ pulseS3Ff);
   // taken before the pin disable, so a disabled pin still interrupts
   assign pulseFall = pulseStableFf & ~pulseS3Ff & pulseAgree;

   // event detection, one bit per status position
   always @* begin
      events = {`MEIM_EV_W{1'b0}};
      events[`MEIM_B_TOTAL_ACTIVE_ENERGY_HALF_EN+0] = |(bit30Now[2:0] ^ bit30PrevFf[2:0]);
      events[`MEIM_B_TOTAL_ACTIVE_ENERGY_HALF_EN+1] = |(bit30Now[5:3] ^ bit30PrevFf[5:3]);
      events[`MEIM_B_TOTAL_ACTIVE_ENERGY_HALF_EN+2] = |(bit30Now[8:6] ^ bit30PrevFf[8:6]);
      events[`MEIM_B_TOTAL_ACTIVE_ENERGY_HALF_EN+3] = |(bit30Now[11:9] ^ bit30PrevFf[11:9]);
      events[`MEIM_B_TOTAL_ACTIVE_ENERGY_HALF_EN+4] = |(bit30Now[14:12] ^ bit30PrevFf[14:12]);
      events[`MEIM_B_LCYC] = lineCycDone;
      events[`MEIM_B_APA+2:`MEIM_B_APA] = actSgnNow ^ actSgnPrevFf;
      events[`MEIM_B_PSUM1] = pulseSumSign[0] ^ sumSgnPrevFf[0];
      events[`MEIM_B_RPA+2:`MEIM_B_RPA] = reactSgnNow ^ reactSgnPrevFf;
      events[`MEIM_B_PSUM2] = pulseSumSign[1] ^ sumSgnPrevFf[1];
      events[`MEIM_B_PULSE1+2:`MEIM_B_PULSE1] = pulseFall;
      events[`MEIM_B_DONE] = dspCycleDone;
      events[`MEIM_B_PSUM3] = pulseSumSign[2] ^ sumSgnPrevFf[2];
   end

   // status: set wins over a clear in the same cycle
   always @* begin
      nxt_statusFf = statusFf;
      if (wrStrobe && hitClear) begin
         nxt_statusFf = statusFf & ~wb_dat_i[`MEIM_EV_W-1:0];
      end
      nxt_statusFf = nxt_statusFf | events;
   end

   // flags latch regardless of mask; the mask only gates the request
   assign irq = |(statusFf & maskFf);

   // history of watched signals and the pulse synchroniser
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bit30PrevFf <= 15'h0000;
         actSgnPrevFf <= 3'h0;
         reactSgnPrevFf <= 3'h0;
         sumSgnPrevFf <= 3'h0;
         pulseS1Ff <= 3'h7;
         pulseS2Ff <= 3'h7;
         pulseS3Ff <= 3'h7;
         pulseStableFf <= 3'h7;
      end else begin
         bit30PrevFf <= bit30Now;
         // selector change may look like a reversal; accepted as rare
         actSgnPrevFf <= actSgnNow;
         reactSgnPrevFf <= reactSgnNow;
         sumSgnPrevFf <= pulseSumSign;
         pulseS1Ff <= pulseNxt;
         pulseS2Ff <= pulseS1Ff;
         pulseS3Ff <= pulseS2Ff;
         pulseStableFf <= (pulseStableFf & ~pulseAgree) | (pulseS3Ff & pulseAgree);
      end
   end

   // register file and bus answer, one wait state
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         maskFf <= `MEIM_RST_MASK;
         statusFf <= {`MEIM_EV_W{1'b0}};
         mmodeFf <= `MEIM_RST_MM;
         cfmodeFf <= `MEIM_RST_CF;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         statusFf <= nxt_statusFf;
         wb_ack_o <= access & mapped;
         wb_err_o <= access & ~mapped;
         if (wrStrobe && hitMask) begin
            // reserved upper bits are not stored and read as zero
            if (wb_sel_i[0]) maskFf[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) maskFf[15:8] <= wb_dat_i[15:8];
            if (wb_sel_i[2]) maskFf[18:16] <= wb_dat_i[18:16];
         end
         if (wrStrobe && hitMm && wb_sel_i[0]) begin
            mmodeFf <= wb_dat_i[`MEIM_MM_W-1:0];
         end
         if (wrStrobe && hitCf) begin
            if (wb_sel_i[0]) cfmodeFf[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) cfmodeFf[11:8] <= wb_dat_i[11:8];
         end
         wb_dat_o <= 32'h00000000;
         if (access && !wb_we_i) begin
            if (hitMask) wb_dat_o <= {{`MEIM_RSV_W{1'b0}}, maskFf};
            else if (hitStatus) wb_dat_o <= {{`MEIM_RSV_W{1'b0}}, statusFf};
            else if (hitMm) wb_dat_o <= {30'h00000000, mmodeFf};
            else if (hitCf) wb_dat_o <= {20'h00000, cfmodeFf};
         end
      end
   end

endmodule
`default_nettype wire

/* logic/meim_regs.vh */
// register map and field layout of the low event interrupt mask block
// included by the mask design file; holds definitions only
`ifndef MEIM_REGS_VH
`define MEIM_REGS_VH

// word offsets as printed are not all multiples of four: index kept, byte = 4*index
`define MEIM_IDX_ENABLE_LOW 16'hE50A
`define MEIM_IDX_STATUS 16'hE50C
`define MEIM_IDX_CLEAR 16'hE50D
`define MEIM_IDX_MEASUREMENT_MODE_REG 16'hE50E
`define MEIM_IDX_PULSE_OUTPUT_MODE_REG 16'hE50F
`define MEIM_ADDR_W 18

// event bit positions
`define MEIM_B_TOTAL_ACTIVE_ENERGY_HALF_EN 0
`define MEIM_B_LCYC 5
`define MEIM_B_APA 6
`define MEIM_B_PSUM1 9
`define MEIM_B_RPA 10
`define MEIM_B_PSUM2 13
`define MEIM_B_PULSE1 14
`define MEIM_B_DONE 17
`define MEIM_B_PSUM3 18
`define MEIM_EV_W 19
`define MEIM_RSV_W 13

// mode register fields
`define MEIM_MM_ACTSEL 0
`define MEIM_MM_REACTSEL 1
`define MEIM_MM_W 2
`define MEIM_CF_W 12
`define MEIM_CF_SEL1_LO 0
`define MEIM_CF_SEL2_LO 3
`define MEIM_CF_SEL3_LO 6
`define MEIM_CF_DIS1 9
`define MEIM_CF_DIS2 10
`define MEIM_CF_DIS3 11

// reset values
`define MEIM_RST_MASK 19'h00000
`define MEIM_RST_MM 2'h0
`define MEIM_RST_CF 12'h000

`endif

/* verification/meim_event_irq_mask_low_asserts.sv */
// checker for the low event mask: bus answers, read data and mode outputs
// bound to the mask top module, sees its ports only
`timescale 1ns/10ps
`default_nettype none
`include "meim_regs.vh"
module meim_event_irq_mask_low_asserts (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`MEIM_ADDR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   // outputs
   input wire logic [2:0] pulseOut1PowerSel,
   input wire logic pulseOut1Disable,
   input wire logic irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // decode kept here so a wrong map in the design shows as a mismatch
   wire logic [15:0] idx = wb_adr_i[17:2];
   wire logic taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire logic mapped = idx == `MEIM_IDX_ENABLE_LOW || (idx >= 16'hE50C && idx <= 16'hE50F);
   wire logic wrCf = wb_ack_o && wb_we_i && idx == `MEIM_IDX_PULSE_OUTPUT_MODE_REG;
   property p_answer;
      taken |=> wb_ack_o == $past(mapped) && wb_err_o == !$past(mapped);
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer wrong");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   property p_err_data;
      wb_err_o |-> wb_dat_o == 32'h0 ##1 !wb_err_o;
   endproperty
   a_err_data: assert property (p_err_data) else $error("error cycle wrong");
   property p_idle_data;
      !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   a_idle_data: assert property (p_idle_data) else $error("read data outside ack");
   property p_rsvd;
      wb_ack_o && !wb_we_i && idx == `MEIM_IDX_ENABLE_LOW |-> wb_dat_o[31:19] == 13'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved mask bits read set");
   property p_rst_quiet;
      $fell(rst) |-> !irq && pulseOut1PowerSel == 3'h0 && !pulseOut1Disable;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("state after reset");
   property p_sel_hold;
      $changed(pulseOut1PowerSel) |-> wrCf;
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("select moved alone");
   property p_dis_hold;
      !wrCf |-> $stable(pulseOut1Disable);
   endproperty
   a_dis_hold: assert property (p_dis_hold) else $error("disable moved alone");
endmodule
`default_nettype wire

/* verification/meim_event_irq_mask_low_test.sv */
// bench for the low event mask: classic bus tasks and event sequences
// drives every design input itself, checker bound at the foot
`timescale 1ns/10ps
`default_nettype none
`include "meim_regs.vh"
module meim_event_irq_mask_low_test;
   logic ref_clk, rst, cyc, stb, we, ack, err, lcd, dsd, irq, ass, rss, e;
   logic [17:0] adr;
   logic [31:0] dat, datO, q;
   logic [14:0] b30;
   logic [2:0] tas, fas, trs, frs, pss, pn, s1, s2, s3, dis;
   int n_mismatch = 0;
   int check_count = 0;
   meim_event_irq_mask_low u_meim_event_irq_mask_low (.ref_clk(ref_clk), .rst(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .wb_err_o(err),
      .totActBit30(b30[2:0]), .fundActBit30(b30[5:3]), .totReactBit30(b30[8:6]),
      .fundReactBit30(b30[11:9]), .apparentBit30(b30[14:12]), .lineCycDone(lcd),
      .totActSign(tas), .fundActSign(fas), .totReactSign(trs), .fundReactSign(frs),
      .pulseSumSign(pss), .energyPulse1N(pn[0]), .energyPulse2N(pn[1]),
      .energyPulse3N(pn[2]), .dspCycleDone(dsd), .pulseOut1PowerSel(s1),
      .pulseOut2PowerSel(s2), .pulseOut3PowerSel(s3), .pulseOut1Disable(dis[0]),
      .pulseOut2Disable(dis[1]), .pulseOut3Disable(dis[2]),
      .activeSignSourceSel(ass), .reactiveSignSourceSel(rss), .irq(irq));
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // one classic cycle; answer looked at mid-cycle to avoid the edge race,
   // request held through the edge that samples it, released right after
   task automatic wbx(input logic w, input logic [15:0] ix, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      {cyc, stb, we, adr, dat} <= {2'b11, w, ix, 2'b00, d};
      do begin
         @(negedge ref_clk);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
      if (ack !== 1'b1 && err !== 1'b1) begin
         n_mismatch++;
         $display("CHECK FAILED bus answer expected ack seen none");
      end
      q = datO;
      e = err;
      @(posedge ref_clk);
      {cyc, stb} <= 2'b00;
      @(negedge ref_clk);
   endtask
   task automatic rd(input logic [15:0] ix, input logic [31:0] ex, input string nm);
      wbx(1'b0, ix, 32'h0);
      chk(nm, ex, q);
   endtask
   // raises the event behind mask bit b; pulse pins fall and come back later
   task automatic trig(input int b);
      @(posedge ref_clk);
      case (b)
         5: lcd <= 1'b1;
         17: dsd <= 1'b1;
         6, 7, 8: tas[b-6] <= ~tas[b-6];
         10, 11, 12: trs[b-10] <= ~trs[b-10];
         9, 13, 18: pss[b/6-1] <= ~pss[b/6-1];
         14, 15, 16: pn[b-14] <= 1'b0;
         default: b30[b*3+b%3] <= ~b30[b*3+b%3];
      endcase
      @(posedge ref_clk);
      {lcd, dsd} <= 2'b00;
      repeat (6) @(posedge ref_clk);
      pn <= 3'h7;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // watchdog far beyond the roughly six hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      summarize();
   end
   initial begin
      {rst, cyc, stb, we, lcd, dsd} = 6'h20;
      {adr, dat, b30, tas, fas, trs, frs, pss} = '0;
      pn = 3'h7;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      rd(`MEIM_IDX_ENABLE_LOW, 32'h0, "mask");
      wbx(1'b1, `MEIM_IDX_ENABLE_LOW, 32'hFFFFFFFF);
      rd(`MEIM_IDX_ENABLE_LOW, 32'h0007FFFF, "mask");
      chk("irq", 32'h0, {31'h0, irq});
      // pins disabled during the loop: pulse interrupts must still come
      wbx(1'b1, `MEIM_IDX_PULSE_OUTPUT_MODE_REG, 32'h00000E5C);
      chk("sel", 32'h5C, {23'h0, s3, s2, s1});
      chk("dis", 32'h7, {29'h0, dis});
      for (int b = 0; b < 19; b++) begin
         wbx(1'b1, `MEIM_IDX_ENABLE_LOW, 32'h1 << b);
         trig(b);
         chk("irq", 32'h1, {31'h0, irq});
         rd(`MEIM_IDX_STATUS, 32'h1 << b, "status");
         wbx(1'b1, `MEIM_IDX_CLEAR, 32'hFFFFFFFF);
         chk("irq", 32'h0, {31'h0, irq});
      end
      @(posedge ref_clk);
      rst <= 1'b1;
      @(posedge ref_clk);
      rst <= 1'b0;
      rd(`MEIM_IDX_ENABLE_LOW, 32'h0, "mask");
      // history restarts at zero, so inputs left high give events: flush them
      wbx(1'b1, `MEIM_IDX_CLEAR, 32'hFFFFFFFF);
      trig(5);
      chk("irq", 32'h0, {31'h0, irq});
      rd(`MEIM_IDX_STATUS, 32'h20, "status");
      wbx(1'b1, `MEIM_IDX_MEASUREMENT_MODE_REG, 32'h3);
      chk("srcsel", 32'h3, {30'h0, rss, ass});
      repeat (8) @(posedge ref_clk);
      wbx(1'b1, `MEIM_IDX_CLEAR, 32'hFFFFFFFF);
      @(posedge ref_clk);
      {fas[0], frs[1]} <= 2'b11;
      trig(6);
      rd(`MEIM_IDX_STATUS, 32'h840, "status");
      wbx(1'b0, 16'hE510, 32'h0);
      chk("err", 32'h1, {31'h0, e});
      chk("udata", 32'h0, q);
      summarize();
   end
endmodule
bind meim_event_irq_mask_low
   meim_event_irq_mask_low_asserts u_meim_event_irq_mask_low_asserts (.ref_clk(ref_clk),
   .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .pulseOut1PowerSel(pulseOut1PowerSel), .pulseOut1Disable(pulseOut1Disable), .irq(irq));
`default_nettype wire
